/* File: hw/hbdc_pkg.sv */
package hbdc_pkg;

  // Clock and time base
  localparam int CLK_PERIOD_NS = 100;

  // Least time in ns to whole cycles, never below one
  function automatic int hbdc_cyc_ceil(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // Longest time in ns to whole cycles, never below one
  function automatic int hbdc_cyc_floor(input int ns);
    int c;
    c = ns / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // Device timing
  localparam int DEAD_MIN_NS   = 200;
  localparam int DEAD_MAX_NS   = 300;
  localparam int DEAD_CYC      = hbdc_cyc_ceil(DEAD_MIN_NS);
  localparam int BLANK_NS      = 2000;
  localparam int BLANK_CYC     = hbdc_cyc_ceil(BLANK_NS);
  localparam int SHORT_NS      = 4000;
  localparam int SHORT_CYC     = hbdc_cyc_ceil(SHORT_NS);
  localparam int TSCP_NS       = 20000;
  localparam int TSCP_CYC_DEF  = hbdc_cyc_ceil(TSCP_NS);
  localparam int SENSE_DIV     = 5;

  // Host timing
  localparam int PWM_MAX_HZ    = 200000;
  localparam int PWM_MIN_CYC   = hbdc_cyc_ceil(1000000000 / PWM_MAX_HZ);
  localparam int PUMP_SETTLE_NS = 200000;
  localparam int PUMP_CYC_DEF  = hbdc_cyc_ceil(PUMP_SETTLE_NS);
  localparam int REV_BRAKE_NS  = 100000;
  localparam int REV_BRAKE_DEF = hbdc_cyc_ceil(REV_BRAKE_NS);

  // Host register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PWM  = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;

  // Control register fields
  localparam int CTRL_EN    = 0;
  localparam int CTRL_RUN   = 1;
  localparam int CTRL_REV   = 2;
  localparam int CTRL_BRAKE = 3;
  localparam int CTRL_AUTO  = 4;
  localparam logic [4:0] CTRL_RST = 5'h00;

  // PWM register fields
  localparam int PWM_PER_LSB  = 0;
  localparam int PWM_DUTY_LSB = 16;
  localparam logic [15:0] PWM_PER_RST  = 16'h0032;
  localparam logic [15:0] PWM_DUTY_RST = 16'h0000;

  // Status register fields
  localparam int STAT_FAULT   = 0;
  localparam int STAT_SETTLED = 1;
  localparam int STAT_SUPPLY  = 2;
  localparam int STAT_REVBRK  = 3;

  // Decoded input command
  typedef enum logic [2:0] {
    CMD_STBY, CMD_OFF, CMD_FWD, CMD_REV, CMD_BRAKE
  } hbdc_cmd_t;

endpackage

/* File: hw/hbdc_if.sv */
interface hbdc_if;
  logic drive_enable_in;
  logic dir_in_a;
  logic dir_in_b;
  logic protect_mode_sel;
  logic fault_flag_out;
  logic fault_flag_out_oe_n;
  logic fault_flag_line_n;

  // Open-drain fault line with pull-up
  assign fault_flag_line_n = fault_flag_out_oe_n ? 1'b1 : fault_flag_out;

  modport dev (
    input  drive_enable_in, dir_in_a, dir_in_b, protect_mode_sel,
    output fault_flag_out, fault_flag_out_oe_n
  );

  modport host (
    output drive_enable_in, dir_in_a, dir_in_b, protect_mode_sel,
    input  fault_flag_line_n
  );
endinterface

/* File: hw/hbdc_device.sv */
// Behaviour
// - Enable low forces off; pins decode modes
// - Leaving drive, low sides decay to zero
// - Inputs follow PWM up to 200 kHz
// - Forward charge high A, low B
// - Reverse charge high B, low A
// - Over limit chops charge, off, brake, off
// - Dead interval before brake, 200-300 ns
// - Limit trips at reference over five
// - Timer period sets brake and short off
// - Sense ignored 2 us after charge entry
// - Short detected on either side switch
// - Mode select low latch, high retry
// - Latch-off cleared by enable cycling
// - Host waits pump settle before drive
// - Drive without motor supply trips short protection
// - Host orders supplies, enable, direction
// - Host brakes between direction changes
// - Enable starts gate rail charge pump
// - Short 4 us: off, retry, then latch
// - Retry mode cycles until short clears
// - Fault flag follows active protection
module hbdc_device
  import hbdc_pkg::*;
#(
  parameter int TSCP_CYC     = TSCP_CYC_DEF,
  parameter bit HAS_MODE_SEL = 1'b1
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Control link
  hbdc_if.dev       link,
  // Analog comparator results
  input  wire logic sense_over_limit,
  input  wire logic short_high_side,
  input  wire logic short_low_side,
  input  wire logic zero_current,
  input  wire logic motor_supply_ok,
  input  wire logic thermal_trip,
  // Bridge gate commands
  output logic      high_side_a,
  output logic      high_side_b,
  output logic      low_side_a,
  output logic      low_side_b,
  // Status
  output logic      pump_run,
  output logic      latched_off
);

  typedef enum logic [2:0] {
    DS_IDLE, DS_CHARGE, DS_DEAD, DS_CHOP, DS_SYNC, DS_BRAKE
  } hbdc_drv_t;

  typedef enum logic [1:0] { PR_RUN, PR_OFF, PR_RETRY, PR_LATCH } hbdc_prot_t;

  localparam int NSYNC = 9;
  localparam int CW    = $clog2(TSCP_CYC + BLANK_CYC + SHORT_CYC + 2);

  logic [NSYNC-1:0] s1_r;
  logic [NSYNC-1:0] s2_r;
  logic             en;
  logic             in_a;
  logic             in_b;
  logic             auto_mode;
  logic             over;
  logic             short_in;
  logic             zc;
  logic             vm_ok;
  logic             therm;
  hbdc_cmd_t        cmd;
  hbdc_drv_t        drv_r;
  hbdc_drv_t        dead_to_r;
  logic             rev_r;
  logic [CW-1:0]    dcnt_r;
  logic [CW-1:0]    blank_r;
  hbdc_prot_t       prot_r;
  logic [CW-1:0]    sc_cnt_r;
  logic [CW-1:0]    tm_r;
  logic             short_now;
  logic             prot_off;
  logic             hs_a_nxt;
  logic             hs_b_nxt;
  logic             ls_a_nxt;
  logic             ls_b_nxt;
  logic             wanted;

  // Two-stage synchroniser on all pins and comparators
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= {thermal_trip, motor_supply_ok, zero_current,
               short_high_side | short_low_side, sense_over_limit,
               link.protect_mode_sel, link.dir_in_b, link.dir_in_a,
               link.drive_enable_in};
      s2_r <= s1_r;
    end
  end

  // Synchronised views
  assign en        = s2_r[0];
  assign in_a      = s2_r[1];
  assign in_b      = s2_r[2];
  assign auto_mode = HAS_MODE_SEL & s2_r[3];
  assign over      = s2_r[4];
  assign short_in  = s2_r[5];
  assign zc        = s2_r[6];
  assign vm_ok     = s2_r[7];
  assign therm     = s2_r[8];

  // Pin decode
  always_comb begin
    if (!en) begin
      cmd = CMD_STBY;
    end else begin
      case ({in_a, in_b})
        2'b10:   cmd = CMD_FWD;
        2'b01:   cmd = CMD_REV;
        2'b11:   cmd = CMD_BRAKE;
        default: cmd = CMD_OFF;
      endcase
    end
  end

  // Command still asks for the present direction
  assign wanted   = (cmd == CMD_FWD && !rev_r) || (cmd == CMD_REV && rev_r);
  assign prot_off = (prot_r == PR_OFF) || (prot_r == PR_LATCH) || therm;

  // Bridge sequencer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      drv_r     <= DS_IDLE;
      dead_to_r <= DS_IDLE;
      rev_r     <= 1'b0;
      dcnt_r    <= '0;
      blank_r   <= '0;
    end else if (!en || prot_off) begin
      drv_r   <= DS_IDLE;
      dcnt_r  <= '0;
      blank_r <= '0;
    end else begin
      if (blank_r != '0) begin
        blank_r <= blank_r - 1'b1;
      end
      case (drv_r)
        DS_IDLE: begin
          if (cmd == CMD_FWD || cmd == CMD_REV) begin
            rev_r   <= (cmd == CMD_REV);
            drv_r   <= DS_CHARGE;
            blank_r <= CW'(BLANK_CYC);
          end else if (cmd == CMD_BRAKE) begin
            drv_r <= DS_BRAKE;
          end
        end
        DS_CHARGE: begin
          if (!wanted) begin
            drv_r     <= DS_DEAD;
            dcnt_r    <= CW'(DEAD_CYC);
            dead_to_r <= (cmd == CMD_BRAKE) ? DS_BRAKE : DS_SYNC;
          end else if (over && blank_r == '0) begin
            drv_r     <= DS_DEAD;
            dcnt_r    <= CW'(DEAD_CYC);
            dead_to_r <= DS_CHOP;
          end
        end
        DS_DEAD: begin
          if (dcnt_r <= CW'(1)) begin
            drv_r <= dead_to_r;
            if (dead_to_r == DS_CHOP) begin
              dcnt_r <= CW'(TSCP_CYC);
            end else if (dead_to_r == DS_CHARGE) begin
              blank_r <= CW'(BLANK_CYC);
            end
          end else begin
            dcnt_r <= dcnt_r - 1'b1;
          end
        end
        DS_CHOP: begin
          if (!wanted) begin
            drv_r <= (cmd == CMD_BRAKE) ? DS_BRAKE : DS_SYNC;
          end else if (dcnt_r <= CW'(1)) begin
            drv_r     <= DS_DEAD;
            dcnt_r    <= CW'(DEAD_CYC);
            dead_to_r <= DS_CHARGE;
          end else begin
            dcnt_r <= dcnt_r - 1'b1;
          end
        end
        // Low sides were on: dead gap before idle, so no shoot-through on recharge
        DS_SYNC: begin
          if (cmd == CMD_BRAKE) begin
            drv_r <= DS_BRAKE;
          end else if (zc) begin
            drv_r     <= DS_DEAD;
            dcnt_r    <= CW'(DEAD_CYC);
            dead_to_r <= DS_IDLE;
          end
        end
        DS_BRAKE: begin
          if (cmd != CMD_BRAKE) begin
            drv_r     <= DS_DEAD;
            dcnt_r    <= CW'(DEAD_CYC);
            dead_to_r <= DS_IDLE;
          end
        end
        default: drv_r <= DS_IDLE;
      endcase
    end
  end

  // Gate pattern per phase
  always_comb begin
    hs_a_nxt = 1'b0;
    hs_b_nxt = 1'b0;
    ls_a_nxt = 1'b0;
    ls_b_nxt = 1'b0;
    case (drv_r)
      DS_CHARGE: begin
        hs_a_nxt = !rev_r;
        ls_b_nxt = !rev_r;
        hs_b_nxt = rev_r;
        ls_a_nxt = rev_r;
      end
      DS_CHOP, DS_SYNC, DS_BRAKE: begin
        ls_a_nxt = 1'b1;
        ls_b_nxt = 1'b1;
      end
      default: ;
    endcase
  end

  // Registered gate outputs
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      high_side_a <= 1'b0;
      high_side_b <= 1'b0;
      low_side_a  <= 1'b0;
      low_side_b  <= 1'b0;
    end else begin
      high_side_a <= hs_a_nxt;
      high_side_b <= hs_b_nxt;
      low_side_a  <= ls_a_nxt;
      low_side_b  <= ls_b_nxt;
    end
  end

  // Short seen, or drive into a dead motor supply
  assign short_now = short_in || (drv_r == DS_CHARGE && !vm_ok);

  // Short-circuit protection
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prot_r   <= PR_RUN;
      sc_cnt_r <= '0;
      tm_r     <= '0;
    end else if (!en) begin
      prot_r   <= PR_RUN;
      sc_cnt_r <= '0;
      tm_r     <= '0;
    end else begin
      if (short_now && (prot_r == PR_RUN || prot_r == PR_RETRY)) begin
        sc_cnt_r <= sc_cnt_r + 1'b1;
      end else begin
        sc_cnt_r <= '0;
      end
      case (prot_r)
        PR_RUN: begin
          if (short_now && sc_cnt_r >= CW'(SHORT_CYC - 1)) begin
            prot_r   <= PR_OFF;
            tm_r     <= CW'(TSCP_CYC);
            sc_cnt_r <= '0;
          end
        end
        PR_OFF: begin
          if (tm_r <= CW'(1)) begin
            prot_r <= auto_mode ? PR_RUN : PR_RETRY;
            tm_r   <= CW'(TSCP_CYC);
          end else begin
            tm_r <= tm_r - 1'b1;
          end
        end
        // Window stays open while the short lasts, so a second detection latches
        PR_RETRY: begin
          if (short_now && sc_cnt_r >= CW'(SHORT_CYC - 1)) begin
            prot_r <= PR_LATCH;
          end else if (tm_r > CW'(1)) begin
            tm_r <= tm_r - 1'b1;
          end else if (!short_now) begin
            prot_r <= PR_RUN;
          end
        end
        PR_LATCH: prot_r <= PR_LATCH;
        default:  prot_r <= PR_RUN;
      endcase
    end
  end

  // Pump, latch status and open-drain fault flag
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pump_run                 <= 1'b0;
      latched_off              <= 1'b0;
      link.fault_flag_out      <= 1'b0;
      link.fault_flag_out_oe_n <= 1'b1;
    end else begin
      pump_run                 <= en;
      latched_off              <= (prot_r == PR_LATCH);
      link.fault_flag_out      <= 1'b0;
      link.fault_flag_out_oe_n <= !prot_off;
    end
  end

endmodule

/* File: hw/hbdc_host.sv */
module hbdc_host
  import hbdc_pkg::*;
#(
  parameter int PUMP_CYC  = PUMP_CYC_DEF,
  parameter int BRAKE_CYC = REV_BRAKE_DEF
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // Supply monitor
  input  wire logic        supplies_ok,
  // Control link
  hbdc_if.host             link
);

  localparam int PW = $clog2(PUMP_CYC + 1);
  localparam int BW = $clog2(BRAKE_CYC + 1);

  logic [4:0]    ctrl_r;
  logic [15:0]   per_r;
  logic [15:0]   duty_r;
  logic [1:0]    sup_s_r;
  logic [1:0]    flt_s_r;
  logic [PW-1:0] settle_r;
  logic [BW-1:0] brk_r;
  logic [15:0]   pcnt_r;
  logic          dir_cur_r;
  logic          settled;
  logic          want;
  logic [15:0]   period;
  logic          a_nxt;
  logic          b_nxt;

  // Register writes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_r <= CTRL_RST;
      per_r  <= PWM_PER_RST;
      duty_r <= PWM_DUTY_RST;
    end else if (wr) begin
      if (addr == REG_CTRL) begin
        ctrl_r <= wdata[4:0];
      end else if (addr == REG_PWM) begin
        per_r  <= wdata[PWM_PER_LSB +: 16];
        duty_r <= wdata[PWM_DUTY_LSB +: 16];
      end
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else if (rd) begin
      case (addr)
        REG_CTRL: rdata <= {27'h0000000, ctrl_r};
        REG_PWM:  rdata <= {duty_r, per_r};
        REG_STAT: rdata <= {28'h0000000, brk_r != '0, sup_s_r[1], settled, !flt_s_r[1]};
        default:  rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

  // Pin synchronisers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sup_s_r <= '0;
      flt_s_r <= 2'h3;
    end else begin
      sup_s_r <= {sup_s_r[0], supplies_ok};
      flt_s_r <= {flt_s_r[0], link.fault_flag_line_n};
    end
  end

  // Enable after supplies, dropped only once direction pins are low
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      link.drive_enable_in  <= 1'b0;
      link.protect_mode_sel <= 1'b0;
    end else begin
      link.protect_mode_sel <= ctrl_r[CTRL_AUTO];
      if (ctrl_r[CTRL_EN] && sup_s_r[1]) begin
        link.drive_enable_in <= 1'b1;
      end else if (!link.dir_in_a && !link.dir_in_b) begin
        link.drive_enable_in <= 1'b0;
      end
    end
  end

  // Pump settle wait after enable
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      settle_r <= '0;
    end else if (!link.drive_enable_in) begin
      settle_r <= '0;
    end else if (settle_r != PW'(PUMP_CYC)) begin
      settle_r <= settle_r + 1'b1;
    end
  end

  assign settled = (settle_r == PW'(PUMP_CYC));
  assign want    = settled && ctrl_r[CTRL_EN] && sup_s_r[1] && ctrl_r[CTRL_RUN];
  assign period  = (per_r < 16'(PWM_MIN_CYC)) ? 16'(PWM_MIN_CYC) : per_r;

  // PWM period counter
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pcnt_r <= '0;
    end else if (!want || pcnt_r >= period - 16'h0001) begin
      pcnt_r <= '0;
    end else begin
      pcnt_r <= pcnt_r + 16'h0001;
    end
  end

  // Brake pause on a direction change
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      brk_r     <= '0;
      dir_cur_r <= 1'b0;
    end else if (brk_r != '0) begin
      brk_r <= brk_r - 1'b1;
      if (brk_r == BW'(1)) begin
        dir_cur_r <= ctrl_r[CTRL_REV];
      end
    end else if (want && ctrl_r[CTRL_REV] != dir_cur_r) begin
      brk_r <= BW'(BRAKE_CYC);
    end else if (!want) begin
      dir_cur_r <= ctrl_r[CTRL_REV];
    end
  end

  // Direction pin pattern
  always_comb begin
    a_nxt = 1'b0;
    b_nxt = 1'b0;
    if (settled && (ctrl_r[CTRL_BRAKE] || brk_r != '0)) begin
      a_nxt = 1'b1;
      b_nxt = 1'b1;
    end else if (want && pcnt_r < duty_r) begin
      a_nxt = !dir_cur_r;
      b_nxt = dir_cur_r;
    end
  end

  // Registered direction pins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      link.dir_in_a <= 1'b0;
      link.dir_in_b <= 1'b0;
    end else begin
      link.dir_in_a <= a_nxt;
      link.dir_in_b <= b_nxt;
    end
  end

endmodule

/* File: verification/hbdc_props.sv */
module hbdc_props
  import hbdc_pkg::*;
#(
  parameter int TSCP_CYC = TSCP_CYC_DEF
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Link pins
  input wire logic drive_enable_in,
  input wire logic dir_in_a,
  input wire logic dir_in_b,
  input wire logic fault_flag_line_n,
  // Fault detectors
  input wire logic short_high_side,
  input wire logic short_low_side,
  input wire logic motor_supply_ok,
  input wire logic thermal_trip,
  // Gates and status
  input wire logic high_side_a,
  input wire logic high_side_b,
  input wire logic low_side_a,
  input wire logic low_side_b,
  input wire logic pump_run,
  input wire logic latched_off
);
  timeunit 1ns;
  timeprecision 1ns;

  logic       hs_any;
  logic       all_off;
  logic       brk;
  logic [7:0] calm_cnt_r;
  logic [7:0] hs_cnt_r;
  logic [7:0] brk_cnt_r;
  logic [7:0] short_cnt_r;

  // Gate summaries
  assign hs_any  = high_side_a | high_side_b;
  assign all_off = ~(hs_any | low_side_a | low_side_b);
  assign brk     = low_side_a & low_side_b & ~hs_any;

  // Run lengths of quiet pins, charge, brake and short
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      calm_cnt_r  <= 8'h00;
      hs_cnt_r    <= 8'h00;
      brk_cnt_r   <= 8'h00;
      short_cnt_r <= 8'h00;
    end else begin
      if ($changed({drive_enable_in, dir_in_a, dir_in_b}) || short_high_side
          || short_low_side || !motor_supply_ok || thermal_trip) begin
        calm_cnt_r <= 8'h00;
      end else if (calm_cnt_r != 8'hFF) begin
        calm_cnt_r <= calm_cnt_r + 8'h01;
      end
      hs_cnt_r  <= hs_any ? hs_cnt_r + 8'h01 : 8'h00;
      brk_cnt_r <= brk ? brk_cnt_r + 8'h01 : 8'h00;
      if (!(short_high_side || short_low_side) || !drive_enable_in) begin
        short_cnt_r <= 8'h00;
      end else if (short_cnt_r != 8'hFF) begin
        short_cnt_r <= short_cnt_r + 8'h01;
      end
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // Two off cycles after charge, and two before it
  sequence s_dead_after;
    all_off ##1 all_off;
  endsequence
  sequence s_dead_before;
    $past(all_off) && $past(all_off, 2);
  endsequence

  a_enable_off: assert property (!drive_enable_in [*5] |-> all_off)
    else $error("gates on with enable low");
  a_fwd_pair: assert property (high_side_a
    |-> low_side_b && !low_side_a && !high_side_b)
    else $error("forward charge pair wrong");
  a_rev_pair: assert property (high_side_b
    |-> low_side_a && !low_side_b && !high_side_a)
    else $error("reverse charge pair wrong");
  a_dead_brake: assert property ($fell(hs_any) |-> s_dead_after)
    else $error("no dead time after charge");
  a_dead_charge: assert property ($rose(hs_any) |-> s_dead_before)
    else $error("no dead time before charge");
  a_blank_hold: assert property (hs_any && hs_cnt_r < 15
    && calm_cnt_r > 60 |=> hs_any)
    else $error("charge left inside blanking");
  a_chop_len: assert property ($fell(brk) && calm_cnt_r > 80
    && (dir_in_a != dir_in_b) |-> brk_cnt_r == TSCP_CYC)
    else $error("chop brake length wrong");
  a_short_off: assert property (short_cnt_r == 50
    |-> all_off && !fault_flag_line_n)
    else $error("short not turned off");
  a_latch_hold: assert property (latched_off && drive_enable_in |=> latched_off)
    else $error("latch released with enable high");
  a_latch_flag: assert property (latched_off [*2] |-> !fault_flag_line_n)
    else $error("fault flag idle while latched");
  a_thermal_flag: assert property (thermal_trip [*6]
    |-> !fault_flag_line_n && all_off)
    else $error("thermal not flagged");
  a_pump_start: assert property (drive_enable_in [*5] |-> pump_run)
    else $error("pump idle with enable high");
endmodule

/* File: verification/test_hbridge_drive_control.sv */
module test_hbridge_drive_control
  import hbdc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct {
    logic [31:0] exp;
    logic [31:0] msk;
  } hbdc_note_t;

  logic        clock, rst, wr, rd, probe, rd_seen, supplies_ok;
  logic        sense_over_limit, short_high_side, short_low_side;
  logic        zero_current, motor_supply_ok, thermal_trip;
  logic        high_side_a, high_side_b, low_side_a, low_side_b, pump_run, latched_off;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, got, rnd;
  logic [6:0]  obs;
  hbdc_note_t  note_q[$];
  hbdc_note_t  note;
  int          err_count, comparisons, cycles;
  logic [4:0]  ctl_tab[4] = '{5'h03, 5'h07, 5'h0B, 5'h01};
  logic [6:0]  obs_tab[4] = '{7'h39, 7'h36, 7'h33, 7'h30};

  hbdc_if u_hbdc_if ();

  hbdc_device #(.TSCP_CYC(20), .HAS_MODE_SEL(1'b1)) u_hbdc_device (
    .clock(clock), .rst(rst), .link(u_hbdc_if), .sense_over_limit(sense_over_limit),
    .short_high_side(short_high_side), .short_low_side(short_low_side),
    .zero_current(zero_current), .motor_supply_ok(motor_supply_ok),
    .thermal_trip(thermal_trip), .high_side_a(high_side_a), .high_side_b(high_side_b),
    .low_side_a(low_side_a), .low_side_b(low_side_b), .pump_run(pump_run),
    .latched_off(latched_off));

  hbdc_host #(.PUMP_CYC(20), .BRAKE_CYC(10)) u_hbdc_host (
    .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .supplies_ok(supplies_ok), .link(u_hbdc_if));

  hbdc_props #(.TSCP_CYC(20)) u_hbdc_props (
    .clock(clock), .rst(rst), .drive_enable_in(u_hbdc_if.drive_enable_in),
    .dir_in_a(u_hbdc_if.dir_in_a), .dir_in_b(u_hbdc_if.dir_in_b),
    .fault_flag_line_n(u_hbdc_if.fault_flag_line_n), .short_high_side(short_high_side),
    .short_low_side(short_low_side), .motor_supply_ok(motor_supply_ok),
    .thermal_trip(thermal_trip), .high_side_a(high_side_a), .high_side_b(high_side_b),
    .low_side_a(low_side_a), .low_side_b(low_side_b), .pump_run(pump_run),
    .latched_off(latched_off));

  // Observed status: latch, fault line, pump, gates
  assign obs = {latched_off, u_hbdc_if.fault_flag_line_n, pump_run,
                high_side_a, high_side_b, low_side_a, low_side_b};

  // Clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic finish_test();
    if (err_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
    note_q.push_back('{e, 32'hFFFFFFFF});
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
  endtask

  task automatic look(input logic [6:0] e, input logic [6:0] m);
    note_q.push_back('{{25'h0, e}, {25'h0, m}});
    @(posedge clock);
    probe <= 1'b1;
    @(posedge clock);
    probe <= 1'b0;
  endtask

  // Result watcher: oldest note against read data or status
  always @(posedge clock) begin
    rd_seen <= rd;
    if (rd_seen || probe) begin
      got = rd_seen ? rdata : {25'h0, obs};
      note = '{32'hFFFFFFFF, 32'h0};
      if (note_q.size() > 0) begin
        note = note_q.pop_front();
      end
      comparisons++;
      if ((note_q.size() == 0 && note.msk === 32'h0) || (got & note.msk) !== note.exp) begin
        $display("BAD t=%0t exp=%h got=%h", $time, note.exp, got);
        err_count++;
      end
    end
  end

  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      finish_test();
    end
  end

  // Main sequence
  initial begin
    {rst, wr, rd, probe, addr, wdata} = {1'b1, 43'h0};
    {sense_over_limit, short_high_side, short_low_side, thermal_trip} = 4'h0;
    {supplies_ok, motor_supply_ok, zero_current} = 3'h7;
    void'($urandom(32'he573f9d8));
    idle(5);
    rst <= 1'b0;
    look(7'h20, 7'h7F);
    reg_rd(REG_CTRL, 32'h0);
    reg_rd(REG_PWM, {PWM_DUTY_RST, PWM_PER_RST});
    reg_rd(8'h10 + 8'($urandom_range(0, 8'hEF)), 32'h0);
    reg_wr(REG_STAT, 32'h0000000F);
    reg_rd(REG_STAT, 32'h4);
    rnd = $urandom;
    reg_wr(REG_PWM, rnd);
    reg_rd(REG_PWM, rnd);
    reg_wr(REG_PWM, 32'hFFFF0032);
    // Forward, reverse, brake and off pin modes in turn
    for (int i = 0; i < 4; i++) begin
      reg_wr(REG_CTRL, {27'h0, ctl_tab[i]});
      idle(80);
      look(obs_tab[i], 7'h7F);
    end
    reg_rd(REG_STAT, 32'h6);
    // Decay to zero current
    zero_current <= 1'b0;
    reg_wr(REG_CTRL, 32'h3);
    idle(60);
    reg_wr(REG_CTRL, 32'h1);
    idle(20);
    look(7'h33, 7'h7F);
    zero_current <= 1'b1;
    idle(10);
    look(7'h30, 7'h7F);
    // Current limit chopping
    reg_wr(REG_CTRL, 32'h3);
    idle(60);
    sense_over_limit <= 1'b1;
    idle(150);
    sense_over_limit <= 1'b0;
    idle(60);
    look(7'h39, 7'h7F);
    // Half duty direct PWM
    reg_wr(REG_PWM, 32'h00190032);
    idle(300);
    reg_wr(REG_PWM, 32'hFFFF0032);
    idle(60);
    look(7'h39, 7'h7F);
    // Thermal trip
    thermal_trip <= 1'b1;
    idle(10);
    look(7'h10, 7'h7F);
    thermal_trip <= 1'b0;
    idle(60);
    look(7'h39, 7'h7F);
    // Latch mode short, cleared by enable cycling
    short_high_side <= 1'b1;
    idle(250);
    look(7'h50, 7'h7F);
    reg_wr(REG_CTRL, 32'h0);
    short_high_side <= 1'b0;
    idle(20);
    look(7'h20, 7'h6F);
    reg_wr(REG_CTRL, 32'h3);
    idle(80);
    look(7'h39, 7'h7F);
    // Auto-retry short
    reg_wr(REG_CTRL, 32'h13);
    short_low_side <= 1'b1;
    idle(300);
    look(7'h00, 7'h40);
    short_low_side <= 1'b0;
    idle(100);
    look(7'h39, 7'h7F);
    // Drive with motor supply missing
    reg_wr(REG_CTRL, 32'h3);
    motor_supply_ok <= 1'b0;
    idle(250);
    look(7'h50, 7'h7F);
    motor_supply_ok <= 1'b1;
    reg_wr(REG_CTRL, 32'h0);
    idle(20);
    look(7'h20, 7'h6F);
    // No enable while the supplies are down
    supplies_ok <= 1'b0;
    reg_wr(REG_CTRL, 32'h3);
    idle(20);
    look(7'h20, 7'h7F);
    finish_test();
  end
endmodule
